// >>> core/rtdc_cfg.svh
// Constants for the RS-485 transceiver direction control block
`ifndef RTDC_CFG_SVH
`define RTDC_CFG_SVH
`define RTDC_MODE_FOUR_WIRE   8'h80
`define RTDC_MODE_ECHO        8'h81
`define RTDC_MODE_TERM_CTRL   8'h82
`define RTDC_MODE_AUTO        8'h83
`define RTDC_FIFO_DEPTH       16
`define RTDC_DATA_W           8
`define RTDC_BAUD_DIV_W       16
`define RTDC_BAUD_DIV_RST     16'h0010
`define RTDC_RX_THRESH_RST    5'h01
`endif

// >>> core/rtdc_pkg.sv
// Types for the RS-485 transceiver direction control block
package rtdc_pkg;
   typedef enum logic [2:0] {
      RTDC_IDLE   = 3'b000,
      RTDC_START  = 3'b001,
      RTDC_DATA   = 3'b011,
      RTDC_PARITY = 3'b010,
      RTDC_STOP   = 3'b110
   } rtdc_bit_state_t;
   typedef enum logic [1:0] {
      RTDC_PAR_NONE = 2'b00,
      RTDC_PAR_EVEN = 2'b01,
      RTDC_PAR_ODD  = 2'b10
   } rtdc_parity_t;
endpackage : rtdc_pkg

// >>> core/rtdc_fifo.sv
// Character FIFO with valid and ready on both sides
`timescale 1ns/1ps
module rtdc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (count != '0);
   assign push      = in_valid & in_ready & ~flush;
   assign pop       = out_valid & out_ready & ~flush;
   assign out_data  = mem[rd_ptr];
   assign level     = count;

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (flush) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count  = '0;
      end else begin
         if (push) next_wr_ptr = AW'(wr_ptr + 1'b1);
         if (pop)  next_rd_ptr = AW'(rd_ptr + 1'b1);
         if (push && !pop) next_count = (AW+1)'(count + 1'b1);
         else if (pop && !push) next_count = (AW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) mem[wr_ptr] <= in_data;
   end
endmodule : rtdc_fifo

// >>> core/rtdc_uart.sv
// Serial port with RS-485 transceiver direction control
`timescale 1ns/1ps
`include "rtdc_cfg.svh"
// Notes on behaviour
// RQ1: Four-wire: driver, receiver always on; reset default.
// RQ2: Echo mode: driver on only while terminal-ready deasserted.
// RQ3: Echo mode: receiver always on, own characters echo.
// RQ4: Terminal-controlled: receiver off whenever driver on.
// RQ5: Auto mode: driver follows transmit-ready per byte.
// RQ6: Auto mode: receiver on only while transmit-ready unasserted.
// RQ7: Terminal-ready and transmit-ready lines are active low.
// RQ8: Host clears terminal-ready bit before sending characters.
// RQ9: Host sets bit only after last character leaves.
// RQ10: Mode codes 128, 129, 130, 131.
// RQ11: Mode loaded at port open, before transfers.
// RQ12: Transmit and receive FIFOs, enabled as pair.
// RQ13: Receive interrupt when level reaches threshold.
// RQ14: Host writes at most transmit block per interrupt.
// RQ15: Host lowers receive threshold at high rates.
// RQ16: Programmable rate, data bits, parity, stop bits.
// RQ17: Flow control halts the character stream.
// RQ18: Auto mode driver on until last stop bit.
module rtdc_uart
   import rtdc_pkg::*;
#(
   parameter int DATA_W = `RTDC_DATA_W,
   parameter int DEPTH  = `RTDC_FIFO_DEPTH
) (
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   input  wire logic                        port_open,
   input  wire logic [7:0]                  mode_sel,
   input  wire logic                        fifo_enable,
   input  wire logic [$clog2(DEPTH):0]      rx_thresh,
   input  wire logic [$clog2(DEPTH):0]      tx_block,
   input  wire logic [`RTDC_BAUD_DIV_W-1:0] baud_div,
   input  wire logic [3:0]                  data_bits,
   input  wire logic [1:0]                  parity_sel,
   input  wire logic                        two_stop,
   input  wire logic                        flow_en,
   input  wire logic                        cts_n,
   input  wire logic                        term_ready_bit,
   input  wire logic [DATA_W-1:0]           tx_data,
   input  wire logic                        tx_valid,
   output logic                             tx_ready,
   output logic [DATA_W-1:0]                rx_data,
   output logic                             rx_valid,
   input  wire logic                        rx_ready,
   output logic                             rx_irq,
   output logic                             tx_irq,
   output logic                             rts_n,
   output logic                             terminal_ready_line,
   output logic                             transmit_ready_line,
   output logic                             txd,
   input  wire logic                        rxd,
   output logic                             driver_en,
   output logic                             receiver_en
);
   // ---------------------------------------------------------------
   // Mode latch
   // ---------------------------------------------------------------
   logic [7:0] mode;
   logic [7:0] next_mode;
   logic       open_q;
   logic       next_open_q;
   always_comb begin
      next_open_q = port_open;
      next_mode   = mode;
      if (port_open && !open_q) next_mode = mode_sel; // [RQ11] [RQ10]
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode   <= `RTDC_MODE_FOUR_WIRE; // [RQ1]
         open_q <= 1'b0;
      end else begin
         mode   <= next_mode;
         open_q <= next_open_q;
      end
   end

   // ---------------------------------------------------------------
   // Transmit FIFO and shifter
   // ---------------------------------------------------------------
   localparam int LW = $clog2(DEPTH) + 1;
   logic [DATA_W-1:0] txf_data;
   logic              txf_valid;
   logic              txf_pop;
   logic [LW-1:0]     txf_level;
   logic [DATA_W-1:0] txf_in;
   logic              txf_in_valid;
   logic              txf_in_ready;

   assign txf_in       = tx_data;
   assign txf_in_valid = tx_valid & (fifo_enable | (txf_level == '0));
   assign tx_ready     = txf_in_ready & (fifo_enable | (txf_level == '0)); // [RQ12]

   rtdc_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .flush     (1'b0),
      .in_data   (txf_in),
      .in_valid  (txf_in_valid),
      .in_ready  (txf_in_ready),
      .out_data  (txf_data),
      .out_valid (txf_valid),
      .out_ready (txf_pop),
      .level     (txf_level)
   );

   rtdc_bit_state_t                tx_st, next_tx_st;
   logic [`RTDC_BAUD_DIV_W-1:0]    tx_cnt, next_tx_cnt;
   logic [3:0]                     tx_bit, next_tx_bit;
   logic [DATA_W-1:0]              tx_sh, next_tx_sh;
   logic                           tx_par, next_tx_par;
   logic                           txd_q, next_txd_q;
   logic                           tx_tick;
   logic                           tx_go;

   assign tx_tick = (tx_cnt == '0);
   assign tx_go   = txf_valid & ~(flow_en & cts_n); // [RQ17]
   assign txf_pop = (tx_st == RTDC_IDLE) & tx_go;

   always_comb begin
      next_tx_st  = tx_st;
      next_tx_cnt = tx_tick ? baud_div : tx_cnt - 1'b1;
      next_tx_bit = tx_bit;
      next_tx_sh  = tx_sh;
      next_tx_par = tx_par;
      next_txd_q  = txd_q;
      case (tx_st)
         RTDC_IDLE: begin
            next_txd_q = 1'b1;
            if (tx_go) begin
               next_tx_sh  = txf_data;
               next_tx_par = (parity_sel == RTDC_PAR_ODD);
               next_tx_bit = '0;
               next_tx_cnt = baud_div;
               next_txd_q  = 1'b0;
               next_tx_st  = RTDC_START;
            end
         end
         RTDC_START: begin
            if (tx_tick) begin
               next_txd_q = tx_sh[0];
               next_tx_par = tx_par ^ tx_sh[0];
               next_tx_sh = tx_sh >> 1;
               next_tx_st = RTDC_DATA;
            end
         end
         RTDC_DATA: begin
            if (tx_tick) begin
               if (tx_bit == data_bits - 4'h1) begin // [RQ16]
                  if (parity_sel == RTDC_PAR_NONE) begin
                     next_txd_q = 1'b1;
                     next_tx_bit = '0;
                     next_tx_st = RTDC_STOP;
                  end else begin
                     next_txd_q = tx_par;
                     next_tx_st = RTDC_PARITY;
                  end
               end else begin
                  next_txd_q  = tx_sh[0];
                  next_tx_par = tx_par ^ tx_sh[0];
                  next_tx_sh  = tx_sh >> 1;
                  next_tx_bit = tx_bit + 4'h1;
               end
            end
         end
         RTDC_PARITY: begin
            if (tx_tick) begin
               next_txd_q  = 1'b1;
               next_tx_bit = '0;
               next_tx_st  = RTDC_STOP;
            end
         end
         default: begin
            if (tx_tick) begin
               if (two_stop && tx_bit == '0) next_tx_bit = 4'h1;
               else next_tx_st = RTDC_IDLE; // [RQ18]
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_st  <= RTDC_IDLE;
         tx_cnt <= '0;
         tx_bit <= '0;
         tx_sh  <= '0;
         tx_par <= 1'b0;
         txd_q  <= 1'b1;
      end else begin
         tx_st  <= next_tx_st;
         tx_cnt <= next_tx_cnt;
         tx_bit <= next_tx_bit;
         tx_sh  <= next_tx_sh;
         tx_par <= next_tx_par;
         txd_q  <= next_txd_q;
      end
   end
   assign txd = txd_q;
   // Transmit-ready active low while a character is queued or on the line
   assign transmit_ready_line = ~(txf_valid | (tx_st != RTDC_IDLE)); // [RQ7] [RQ18]
   assign tx_irq = (txf_level <= tx_block) ? 1'b1 : 1'b0; // [RQ14]
   // Setting the control bit asserts the active-low line; clearing it frees the driver
   assign terminal_ready_line = ~term_ready_bit; // [RQ7] [RQ8] [RQ9]

   // ---------------------------------------------------------------
   // Transceiver enables
   // ---------------------------------------------------------------
   always_comb begin
      driver_en   = 1'b1;
      receiver_en = 1'b1;
      if (mode == `RTDC_MODE_ECHO) begin
         driver_en   = terminal_ready_line; // [RQ2] [RQ7]
         receiver_en = 1'b1; // [RQ3]
      end else if (mode == `RTDC_MODE_TERM_CTRL) begin
         driver_en   = terminal_ready_line; // [RQ4]
         receiver_en = ~terminal_ready_line; // [RQ4]
      end else if (mode == `RTDC_MODE_AUTO) begin
         driver_en   = ~transmit_ready_line; // [RQ5] [RQ7]
         receiver_en = transmit_ready_line; // [RQ6]
      end
   end

   // ---------------------------------------------------------------
   // Receiver
   // ---------------------------------------------------------------
   rtdc_bit_state_t             rx_st, next_rx_st;
   logic [`RTDC_BAUD_DIV_W-1:0] rx_cnt, next_rx_cnt;
   logic [3:0]                  rx_bit, next_rx_bit;
   logic [DATA_W-1:0]           rx_sh, next_rx_sh;
   logic                        rx_push, next_rx_push;
   logic                        rx_in;
   logic                        rx_tick;
   logic                        rxf_ready;
   logic [LW-1:0]               rxf_level;

   assign rx_in   = rxd | ~receiver_en;
   assign rx_tick = (rx_cnt == '0);

   always_comb begin
      next_rx_st   = rx_st;
      next_rx_cnt  = rx_tick ? baud_div : rx_cnt - 1'b1;
      next_rx_bit  = rx_bit;
      next_rx_sh   = rx_sh;
      next_rx_push = 1'b0;
      case (rx_st)
         RTDC_IDLE: begin
            if (!rx_in) begin
               next_rx_cnt = {1'b0, baud_div[`RTDC_BAUD_DIV_W-1:1]};
               next_rx_st  = RTDC_START;
            end
         end
         RTDC_START: begin
            if (rx_tick) begin
               next_rx_bit = '0;
               next_rx_st  = rx_in ? RTDC_IDLE : RTDC_DATA;
            end
         end
         RTDC_DATA: begin
            if (rx_tick) begin
               next_rx_sh  = {rx_in, rx_sh[DATA_W-1:1]};
               next_rx_bit = rx_bit + 4'h1;
               if (rx_bit == data_bits - 4'h1)
                  next_rx_st = (parity_sel == RTDC_PAR_NONE) ? RTDC_STOP : RTDC_PARITY;
            end
         end
         RTDC_PARITY: begin
            if (rx_tick) next_rx_st = RTDC_STOP;
         end
         default: begin
            if (rx_tick) begin
               next_rx_sh   = rx_sh >> (4'(DATA_W) - data_bits);
               next_rx_push = rx_in;
               next_rx_st   = RTDC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_st   <= RTDC_IDLE;
         rx_cnt  <= '0;
         rx_bit  <= '0;
         rx_sh   <= '0;
         rx_push <= 1'b0;
      end else begin
         rx_st   <= next_rx_st;
         rx_cnt  <= next_rx_cnt;
         rx_bit  <= next_rx_bit;
         rx_sh   <= next_rx_sh;
         rx_push <= next_rx_push;
      end
   end

   rtdc_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .flush     (1'b0),
      .in_data   (rx_sh),
      .in_valid  (rx_push & (fifo_enable | (rxf_level == '0))), // [RQ12]
      .in_ready  (rxf_ready),
      .out_data  (rx_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .level     (rxf_level)
   );
   assign rts_n  = ~(rxf_ready & (fifo_enable | (rxf_level == '0))); // [RQ17]
   assign rx_irq = rx_valid & ((rxf_level >= rx_thresh) | ~fifo_enable); // [RQ13]
endmodule : rtdc_uart

// >>> dv/rtdc_uart_assertions.sv
// Checker for the transceiver enables and transmit launch
`timescale 1ns/1ps
`include "rtdc_cfg.svh"
module rtdc_uart_checker (
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       port_open,
   input wire logic [7:0] mode_sel,
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic       flow_en,
   input wire logic       cts_n,
   input wire logic       fifo_enable,
   input wire logic       rx_valid,
   input wire logic       rx_irq,
   input wire logic       terminal_ready_line,
   input wire logic       transmit_ready_line,
   input wire logic       txd,
   input wire logic       driver_en,
   input wire logic       receiver_en
);
   logic [7:0] mode;
   logic [7:0] next_mode;
   logic       po_d;
   logic       po_d2;
   logic       quiet;
   logic       four;
   always_comb begin
      next_mode = (port_open && !po_d) ? mode_sel : mode;
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode  <= `RTDC_MODE_FOUR_WIRE;
         po_d  <= 1'b0;
         po_d2 <= 1'b0;
      end else begin
         mode  <= next_mode;
         po_d  <= port_open;
         po_d2 <= po_d;
      end
   end
   // Skip the cycles in which a new mode is being taken
   assign quiet = !(port_open && !po_d) && !(po_d && !po_d2);
   assign four  = !(mode inside {`RTDC_MODE_ECHO, `RTDC_MODE_TERM_CTRL, `RTDC_MODE_AUTO});
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      tx_valid && tx_ready && transmit_ready_line && !(flow_en && cts_n);
   endsequence
   sequence s_launch;
      !transmit_ready_line ##1 !txd;
   endsequence
   property p_four; quiet && four |-> driver_en && receiver_en; endproperty
   property p_echo_drv; quiet && mode == `RTDC_MODE_ECHO |-> driver_en == terminal_ready_line; endproperty
   property p_echo_rx; quiet && mode == `RTDC_MODE_ECHO |-> receiver_en; endproperty
   property p_term; quiet && mode == `RTDC_MODE_TERM_CTRL |-> driver_en == terminal_ready_line && receiver_en == !driver_en; endproperty
   property p_auto_drv; quiet && mode == `RTDC_MODE_AUTO |-> driver_en == !transmit_ready_line; endproperty
   property p_auto_rx; quiet && mode == `RTDC_MODE_AUTO |-> receiver_en == transmit_ready_line; endproperty
   property p_start; s_take |=> s_launch; endproperty
   property p_idle; transmit_ready_line |-> txd; endproperty
   property p_irq_empty; !rx_valid |-> !rx_irq; endproperty
   property p_irq_single; rx_valid && !fifo_enable |-> rx_irq; endproperty
   a_four: assert property (p_four) else $error("enables off in four-wire");
   a_echo_drv: assert property (p_echo_drv) else $error("echo driver enable wrong");
   a_echo_rx: assert property (p_echo_rx) else $error("echo receiver off");
   a_term: assert property (p_term) else $error("terminal mode enables wrong");
   a_auto_drv: assert property (p_auto_drv) else $error("auto driver enable wrong");
   a_auto_rx: assert property (p_auto_rx) else $error("auto receiver enable wrong");
   a_start: assert property (p_start) else $error("start bit late");
   a_idle: assert property (p_idle) else $error("line not idle high");
   a_irq_empty: assert property (p_irq_empty) else $error("irq without data");
   a_irq_single: assert property (p_irq_single) else $error("irq missing");
endmodule : rtdc_uart_checker
bind rtdc_uart rtdc_uart_checker u_chk (.*);

// >>> dv/rtdc_remote.sv
// Remote station on the serial pair: sends and decodes frames
`timescale 1ns/1ps
module rtdc_remote (
   input  wire logic clk_sys,
   input  wire logic two_wire,
   input  wire logic txd,
   input  wire logic driver_en,
   output logic      rxd
);
   int         bit_clks = 4;
   int         nbits    = 8;
   int         par      = 0;
   int         nstop    = 1;
   logic       rline    = 1'b1;
   logic [7:0] got_q[$];
   int         bad      = 0;
   // Shared pair in two-wire; bias holds the idle line high
   assign rxd = (two_wire && driver_en) ? txd : rline;
   function automatic logic pbit(input logic [7:0] d);
      logic p;
      p = ^(d & 8'((1 << nbits) - 1));
      return (par == 2) ? ~p : p;
   endfunction : pbit
   task automatic put(input logic b);
      rline = b;
      repeat (bit_clks) @(negedge clk_sys);
   endtask : put
   task automatic send(input logic [7:0] d);
      put(1'b0);
      for (int i = 0; i < nbits; i++) put(d[i]);
      if (par != 0) put(pbit(d));
      repeat (nstop) put(1'b1);
   endtask : send
   always begin
      logic [7:0] v;
      @(negedge clk_sys iff (driver_en === 1'b1 && txd === 1'b0));
      repeat (bit_clks / 2) @(negedge clk_sys);
      v = 8'h00;
      for (int i = 0; i < nbits; i++) begin
         repeat (bit_clks) @(negedge clk_sys);
         v[i] = txd;
      end
      if (par != 0) begin
         repeat (bit_clks) @(negedge clk_sys);
         if (txd !== pbit(v)) bad++;
      end
      repeat (nstop) begin
         repeat (bit_clks) @(negedge clk_sys);
         if (txd !== 1'b1 || driver_en !== 1'b1) bad++;
      end
      got_q.push_back(v);
   end
endmodule : rtdc_remote

// >>> dv/rtdc_uart_bench.sv
// Self-checking bench for the RS-485 direction control port
`timescale 1ns/1ps
`include "rtdc_cfg.svh"
module rtdc_uart_bench;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        port_open = 1'b0;
   logic [7:0]  mode_sel = 8'h80;
   logic        fifo_enable = 1'b0;
   logic [4:0]  rx_thresh = 5'h01;
   logic [4:0]  tx_block = 5'h04;
   logic [15:0] baud_div = 16'h0003;
   logic [3:0]  data_bits = 4'h8;
   logic [1:0]  parity_sel = 2'h0;
   logic        two_stop = 1'b0;
   logic        flow_en = 1'b0;
   logic        cts_n = 1'b0;
   logic        term_ready_bit = 1'b1;
   logic [7:0]  tx_data = 8'h00;
   logic        tx_valid = 1'b0;
   logic        rx_ready = 1'b0;
   logic        two_wire = 1'b0;
   logic        tx_ready, rx_valid, rx_irq, tx_irq, rts_n, txd, rxd;
   logic        terminal_ready_line, transmit_ready_line, driver_en, receiver_en;
   logic [7:0]  rx_data, d, e, q, msk;
   int          failures = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          n;
   rtdc_uart u_dut (.*);
   rtdc_remote u_remote (.*);
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (failures == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
      tests_run++;
      if (g !== x) begin
         $display("[ERR] %s expected %h seen %h", s, x, g);
         failures++;
      end
   endtask : chk
   function automatic logic [7:0] exp_en(input logic [7:0] m, input logic trb);
      case (m)
         `RTDC_MODE_ECHO:      return {6'h00, ~trb, 1'b1};
         `RTDC_MODE_TERM_CTRL: return {6'h00, ~trb, trb};
         `RTDC_MODE_AUTO:      return 8'h01;
         default:              return 8'h03;
      endcase
   endfunction : exp_en
   task automatic cfg(input logic [7:0] m);
      mode_sel = m;
      two_wire = (m != `RTDC_MODE_FOUR_WIRE);
      port_open = 1'b1;
      repeat (3) @(negedge clk_sys);
      port_open = 1'b0;
      u_remote.bit_clks = baud_div + 1;
      u_remote.nbits = data_bits;
      u_remote.par = parity_sel;
      u_remote.nstop = two_stop + 1;
      msk = 8'((1 << data_bits) - 1);
      u_remote.got_q.delete();
      @(negedge clk_sys);
   endtask : cfg
   task automatic wr(input logic [7:0] v);
      tx_data = v;
      tx_valid = 1'b1;
      do @(posedge clk_sys); while (tx_ready !== 1'b1);
      @(negedge clk_sys);
   endtask : wr
   task automatic rd(output logic [7:0] v);
      rx_ready = 1'b1;
      while (rx_valid !== 1'b1) @(negedge clk_sys);
      v = rx_data;
      @(negedge clk_sys);
   endtask : rd
   task automatic fill(output int k);
      k = 0;
      tx_valid = 1'b1;
      repeat (20) begin
         tx_data = 8'(k);
         @(posedge clk_sys);
         if (tx_ready === 1'b1) k++;
         @(negedge clk_sys);
      end
      tx_valid = 1'b0;
   endtask : fill
   task automatic wait_q(input int k);
      n = 0;
      while (u_remote.got_q.size() < k && n < 4000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 4000) begin
         $display("[ERR] frames expected %0d seen %0d", k, u_remote.got_q.size());
         failures++;
      end
   endtask : wait_q
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      d = 8'($urandom(95367));
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      chk("en_rst", 8'h03, {6'h00, driver_en, receiver_en});
      chk("rts_rst", 8'h00, {7'h00, rts_n});
      for (int m = 0; m < 5; m++) begin
         cfg(8'h80 + 8'(m));
         for (int t = 0; t < 2; t++) begin
            term_ready_bit = t[0];
            @(negedge clk_sys);
            chk("en_mode", exp_en(mode_sel, t[0]), {6'h00, driver_en, receiver_en});
            chk("trl", 8'(!t[0]), {7'h00, terminal_ready_line});
         end
         mode_sel = 8'h82;
         @(negedge clk_sys);
         chk("en_kept", exp_en(8'h80 + 8'(m), 1'b1), {6'h00, driver_en, receiver_en});
      end
      for (int k = 0; k < 8; k++) begin
         baud_div = 16'($urandom_range(9, 3));
         data_bits = 4'($urandom_range(8, 5));
         parity_sel = 2'($urandom_range(2, 0));
         two_stop = 1'($urandom_range(1, 0));
         fifo_enable = 1'($urandom_range(1, 0));
         d = (k < 2) ? {8{k[0]}} : 8'($urandom);
         e = 8'($urandom);
         cfg(8'h80 + 8'(k % 4));
         term_ready_bit = 1'b0;
         @(negedge clk_sys);
         wr(d);
         tx_valid = 1'b0;
         wait_q(1);
         chk("tx_frame", d & msk, u_remote.got_q.pop_front());
         repeat (3 * (baud_div + 1)) @(negedge clk_sys);
         chk("echo", 8'(mode_sel == `RTDC_MODE_ECHO), {7'h00, rx_valid});
         chk("rts", 8'(mode_sel == `RTDC_MODE_ECHO && !fifo_enable), {7'h00, rts_n});
         if (mode_sel == `RTDC_MODE_ECHO) begin
            rd(q);
            rx_ready = 1'b0;
            chk("echo_data", d & msk, q);
         end
         term_ready_bit = 1'b1;
         @(negedge clk_sys);
         u_remote.send(e);
         rd(q);
         rx_ready = 1'b0;
         chk("rx_frame", e & msk, q);
      end
      chk("frame_bad", 8'h00, 8'(u_remote.bad));
      baud_div = 16'h0003;
      data_bits = 4'h8;
      parity_sel = 2'h0;
      two_stop = 1'b0;
      fifo_enable = 1'b1;
      cfg(`RTDC_MODE_AUTO);
      flow_en = 1'b1;
      cts_n = 1'b1;
      fill(n);
      chk("fill", 8'h10, 8'(n));
      chk("halt", 8'h01, {7'h00, txd});
      chk("tx_irq_full", 8'h00, {7'h00, tx_irq});
      cts_n = 1'b0;
      wait_q(16);
      for (int i = 0; i < 16; i++) chk("tx_order", 8'(i), u_remote.got_q.pop_front());
      chk("tx_irq_empty", 8'h01, {7'h00, tx_irq});
      fifo_enable = 1'b0;
      cts_n = 1'b1;
      fill(n);
      chk("fill_off", 8'h01, 8'(n));
      cts_n = 1'b0;
      wait_q(1);
      chk("single", 8'h00, u_remote.got_q.pop_front());
      fifo_enable = 1'b1;
      rx_thresh = 5'h03;
      repeat (4 * (baud_div + 1)) @(negedge clk_sys);
      for (int i = 0; i < 2; i++) u_remote.send(8'ha0 + 8'(i));
      repeat (4) @(negedge clk_sys);
      chk("irq_low", 8'h00, {7'h00, rx_irq});
      u_remote.send(8'ha2);
      repeat (4) @(negedge clk_sys);
      chk("irq_high", 8'h01, {7'h00, rx_irq});
      for (int i = 0; i < 3; i++) begin
         rd(q);
         chk("rx_order", 8'ha0 + 8'(i), q);
      end
      rx_ready = 1'b0;
      print_verdict();
   end
endmodule : rtdc_uart_bench
